/* File: pkg/carf_pkg.sv */
// Constants and types for the architectural register file.
// Assumes a single core clock; no software-visible bus.
package carf_pkg;
    localparam int CARF_NUM_GPR = 16;
    localparam int CARF_SHORT_W = 16;
    localparam int CARF_LONG_W = 32;
    localparam int CARF_PC_W = 24;
    localparam int CARF_FIRST_LONG = 12;
    localparam logic [3:0] CARF_IDX_RET = 4'hE;
    localparam logic [3:0] CARF_IDX_SP = 4'hF;
    localparam logic [31:0] CARF_ADDR_LIMIT = 32'h00FF_FFFF;
    localparam logic [31:0] CARF_ISTK_KEEP = 32'h00FF_FFFE;
    localparam logic [23:0] CARF_PC_RST = 24'h00_0000;
    localparam logic [31:0] CARF_REG_RST = 32'h0000_0000;
    localparam logic [15:0] CARF_CFG_RST = 16'h0000;
    localparam int CARF_CFG_SHORT_BIT = 9;
    localparam int CARF_PSW_USER_BIT = 3;
    localparam int CARF_PAIR_SHORT_TOP = 13;
    // Access sizes of one register port
    typedef enum logic [1:0] {
        CARF_SZ_BYTE,
        CARF_SZ_WORD,
        CARF_SZ_PAIR
    } carf_size_t;
    // Dedicated register selects
    typedef enum logic [2:0] {
        CARF_DR_NONE,
        CARF_DR_PC,
        CARF_DR_ISTK,
        CARF_DR_USTK,
        CARF_DR_BASE,
        CARF_DR_PSW,
        CARF_DR_CFG
    } carf_dreg_t;
endpackage

/* File: design/carf_regfile.sv */
// Architectural register file of the 16-bit core: sixteen general
// registers with mode dependent pairing, dedicated address registers,
// status and configuration words, stack selection and address trap.
// Assumes the execution unit drives requests on the core clock.
`timescale 1ns/10ps
module carf_regfile
    import carf_pkg::*;
#(
    parameter logic [23:0] PC_START = CARF_PC_RST
)
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic warm_rst,
    // General register read port
    input wire logic [3:0] rd_idx,
    input wire carf_size_t rd_size,
    output logic [31:0] rd_data,
    // General register write port
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire carf_size_t wr_size,
    input wire logic [31:0] wr_data,
    // Dedicated register access
    input wire carf_dreg_t dr_sel,
    input wire logic dr_wr,
    input wire logic [31:0] dr_wdata,
    output logic [31:0] dr_rdata,
    // Program counter update
    input wire logic pc_ld,
    input wire logic [23:0] pc_next,
    output logic [23:0] pc,
    // Stack use
    input wire logic stk_access,
    input wire logic exc_stk_access,
    output logic [31:0] stack_ptr,
    output logic [31:0] interrupt_stack_pointer,
    output logic illegal_address_trap,
    output logic short_register_select
);
    ////////////////////////////////////////////////////////////////////
    // Storage: every general register entry is 32 bits; narrow ones keep upper half zero
    logic [31:0] gpr_q [CARF_NUM_GPR];
    logic [23:0] pc_q;
    logic [31:0] istk_q;
    logic [31:0] ustk_q;
    logic [31:0] base_q;
    logic [15:0] psw_q;
    logic [15:0] cfg_q;
    logic trap_q;

    wire short_mode = cfg_q[CARF_CFG_SHORT_BIT];
    wire user_mode = psw_q[CARF_PSW_USER_BIT];
    wire [3:0] rd_hi = rd_idx + 4'h1;
    wire [3:0] wr_hi = wr_idx + 4'h1;
    // pair uses low halves in short mode, except R15 which is one 32-bit register
    // single 32-bit register in native mode from R12 upward
    wire rd_single = !short_mode && (rd_idx >= 4'(CARF_FIRST_LONG));
    wire wr_single = !short_mode && (wr_idx >= 4'(CARF_FIRST_LONG));
    wire rd_sp_pair = short_mode && (rd_idx == CARF_IDX_SP);
    wire wr_sp_pair = short_mode && (wr_idx == CARF_IDX_SP);
    wire [15:0] rd_lo_w = gpr_q[rd_idx][15:0];
    wire [15:0] rd_hi_w = gpr_q[rd_hi][15:0];
    // byte read gives only low byte
    // word read uses only the lower word
    assign rd_data =
        (rd_size == CARF_SZ_BYTE) ? {24'h00_0000, rd_lo_w[7:0]} :
        (rd_size == CARF_SZ_WORD) ? {16'h0000, rd_lo_w} :
        (rd_single || rd_sp_pair) ? gpr_q[rd_idx] :
        {rd_hi_w, rd_lo_w};

    assign stack_ptr = user_mode ? ustk_q : gpr_q[CARF_IDX_SP];
    // interrupt stack always exposed on its own output and through dr_rdata, never through stack_ptr
    assign interrupt_stack_pointer = istk_q;
    // user stack above 24-bit space is an illegal address
    wire trap_hit = stk_access && !exc_stk_access && user_mode &&
        (ustk_q > CARF_ADDR_LIMIT);
    assign illegal_address_trap = trap_q;
    assign short_register_select = short_mode;
    assign pc = pc_q;
    assign dr_rdata =
        (dr_sel == CARF_DR_PC) ? {8'h00, pc_q} :
        (dr_sel == CARF_DR_ISTK) ? istk_q :
        (dr_sel == CARF_DR_USTK) ? ustk_q :
        (dr_sel == CARF_DR_BASE) ? base_q :
        (dr_sel == CARF_DR_PSW) ? {16'h0000, psw_q} :
        (dr_sel == CARF_DR_CFG) ? {16'h0000, cfg_q} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // General registers, one generate entry each
    for (genvar i = 0; i < CARF_NUM_GPR; i++)
    begin : g_gpr
        localparam bit LONG = (i >= CARF_FIRST_LONG);
        wire hit_lo = wr_en && (wr_idx == 4'(i));
        wire hit_hi = wr_en && (wr_size == CARF_SZ_PAIR) && !wr_single &&
            !wr_sp_pair && (wr_hi == 4'(i)) && (wr_idx != CARF_IDX_SP);
        logic [31:0] nxt;
        always_comb
        begin
            nxt = gpr_q[i];
            if (hit_lo)
            begin
                // byte write leaves upper part untouched
                if (wr_size == CARF_SZ_BYTE)
                    nxt[7:0] = wr_data[7:0];
                // word write leaves upper word untouched
                else if (wr_size == CARF_SZ_WORD)
                    nxt[15:0] = wr_data[15:0];
                else if (wr_single || wr_sp_pair)
                    nxt = wr_data;
                else
                    nxt[15:0] = wr_data[15:0];
            end
            else if (hit_hi)
                nxt[15:0] = wr_data[31:16];
            // narrow registers hold 16 bits only
            if (!LONG)
                nxt[31:16] = 16'h0000;
        end
        always_ff @(posedge clock or posedge sys_rst)
        begin
            if (sys_rst)
                gpr_q[i] <= CARF_REG_RST;
            else if (clk_en)
            begin
                // previous PC lands in pair (R1,R0)
                if (warm_rst && i == 0)
                    gpr_q[i] <= {16'h0000, pc_q[15:0]};
                else if (warm_rst && i == 1)
                    gpr_q[i] <= {24'h00_0000, pc_q[23:16]};
                else if (!warm_rst)
                    gpr_q[i] <= nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Dedicated registers
    wire dw_pc = dr_wr && (dr_sel == CARF_DR_PC);
    wire dw_istk = dr_wr && (dr_sel == CARF_DR_ISTK);
    wire dw_ustk = dr_wr && (dr_sel == CARF_DR_USTK);
    wire dw_base = dr_wr && (dr_sel == CARF_DR_BASE);
    wire dw_psw = dr_wr && (dr_sel == CARF_DR_PSW);
    wire dw_cfg = dr_wr && (dr_sel == CARF_DR_CFG);
    wire [23:0] pc_d = dw_pc ? {dr_wdata[23:1], 1'b0} :
        {pc_next[23:1], 1'b0};
    // base stored as written; software keeps reserved bits zero
    // reserved bits stored as given, no check
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pc_q <= {PC_START[23:1], 1'b0};
            istk_q <= CARF_REG_RST;
            ustk_q <= CARF_REG_RST;
            base_q <= CARF_REG_RST;
            psw_q <= CARF_CFG_RST;
            cfg_q <= CARF_CFG_RST;
            trap_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (warm_rst)
            begin
                pc_q <= {PC_START[23:1], 1'b0};
                cfg_q <= CARF_CFG_RST;
            end
            else
            begin
                if (pc_ld || dw_pc)
                    pc_q <= pc_d;
                // reserved interrupt stack bits forced zero
                if (dw_istk)
                    istk_q <= dr_wdata & CARF_ISTK_KEEP;
                if (dw_ustk)
                    ustk_q <= dr_wdata;
                if (dw_base)
                    base_q <= dr_wdata;
                if (dw_psw)
                    psw_q <= dr_wdata[15:0];
                if (dw_cfg)
                    cfg_q <= dr_wdata[15:0];
            end
            trap_q <= trap_hit && !warm_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_ISTK_ZERO: assert property (
        (istk_q & ~CARF_ISTK_KEEP) == 32'h0000_0000)
        else $error("interrupt stack reserved bits not zero");
    AST_ISTK_WRITE: assert property (clk_en && dw_istk && !warm_rst
        |=> istk_q == ($past(dr_wdata) & CARF_ISTK_KEEP))
        else $error("interrupt stack write not masked");
    AST_PC_EVEN: assert property (pc_q[0] == 1'b0)
        else $error("pc odd");
    AST_WARM_PC: assert property (clk_en && warm_rst |=>
        {gpr_q[1][7:0], gpr_q[0][15:0]} == $past(pc_q))
        else $error("warm reset lost pc");
    AST_WARM_CFG: assert property (clk_en && warm_rst |=> !short_mode)
        else $error("config not cleared");
    // Trap is a cause in one cycle and a pulse in the next
    sequence s_trap_cause;
        clk_en && !warm_rst && trap_hit;
    endsequence
    sequence s_trap_quiet;
        clk_en && !(trap_hit && !warm_rst);
    endsequence
    AST_TRAP: assert property (s_trap_cause |=> trap_q)
        else $error("trap not raised");
    AST_TRAP_END: assert property (s_trap_quiet |=> !trap_q)
        else $error("trap without cause");
    AST_STACK_SEL: assert property (user_mode |-> stack_ptr == ustk_q)
        else $error("wrong stack in user mode");
    AST_NARROW: assert property (gpr_q[11][31:16] == 16'h0000)
        else $error("narrow register upper bits set");
    AST_BYTE_KEEP: assert property (clk_en && !warm_rst && wr_en &&
        wr_size == CARF_SZ_BYTE && wr_idx == 4'h2 |=>
        gpr_q[2][15:8] == $past(gpr_q[2][15:8]))
        else $error("byte write touched upper byte");
endmodule // carf_regfile

/* File: tb/carf_exec_model.sv */
// Execution side model: issues register file requests.
// Assumes requests change on the falling clock edge only.
`timescale 1ns/10ps
module carf_exec_model
    import carf_pkg::*;
(
    // Clock
    input wire logic clock,
    // Requests toward the register file
    output logic clk_en = 1'b1,
    output logic warm_rst = 1'b0,
    output logic [3:0] rd_idx = 4'h0,
    output carf_size_t rd_size = CARF_SZ_WORD,
    output logic wr_en = 1'b0,
    output logic [3:0] wr_idx = 4'h0,
    output carf_size_t wr_size = CARF_SZ_WORD,
    output logic [31:0] wr_data = 32'h0000_0000,
    output carf_dreg_t dr_sel = CARF_DR_NONE,
    output logic dr_wr = 1'b0,
    output logic [31:0] dr_wdata = 32'h0000_0000,
    output logic pc_ld = 1'b0,
    output logic [23:0] pc_next = 24'h00_0000,
    output logic stk_access = 1'b0,
    output logic exc_stk_access = 1'b0
);
    ////////////////////////////////////////////////////////////////////
    // Released data lines show the inverse so stale values never match
    task automatic gpr_wr(input logic [3:0] i, input carf_size_t s,
                          input logic [31:0] d, input logic en);
        @(negedge clock);
        clk_en <= en;
        wr_en <= 1'b1;
        wr_idx <= i;
        wr_size <= s;
        wr_data <= d;
        @(negedge clock);
        clk_en <= 1'b1;
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask
    task automatic dr_write(input carf_dreg_t s, input logic [31:0] d);
        @(negedge clock);
        dr_sel <= s;
        dr_wr <= 1'b1;
        dr_wdata <= (s == CARF_DR_BASE) ? (d & 32'h00FF_FFFE) : d;
        @(negedge clock);
        dr_wr <= 1'b0;
        dr_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] i, input carf_size_t s);
        @(negedge clock);
        rd_idx <= i;
        rd_size <= s;
        #1;
    endtask
    // Kind 0 loads pc, 1 warm reset, 2 user stack, 3 exception stack
    task automatic pulse(input int k, input logic [23:0] p);
        @(negedge clock);
        pc_next <= p;
        pc_ld <= (k == 0);
        warm_rst <= (k == 1);
        stk_access <= (k >= 2);
        exc_stk_access <= (k == 3);
        @(negedge clock);
        pc_ld <= 1'b0;
        warm_rst <= 1'b0;
        stk_access <= 1'b0;
        exc_stk_access <= 1'b0;
    endtask
endmodule // carf_exec_model

/* File: tb/carf_regfile_tb.sv */
// Self-checking bench for the architectural register file.
// Assumes the model drives all requests on the falling edge.
`timescale 1ns/10ps
module carf_regfile_tb;
    import carf_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en, warm_rst, wr_en, dr_wr, pc_ld, stk_access, exc_acc;
    logic [3:0] rd_idx, wr_idx;
    carf_size_t rd_size, wr_size;
    carf_dreg_t dr_sel;
    logic [31:0] wr_data, dr_wdata, rd_data, dr_rdata, sp, istk;
    logic [23:0] pc_next, pc;
    logic trap, srs;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    carf_regfile #(.PC_START(24'h00_1235)) i_carf_regfile (.clock(clock),
        .sys_rst(sys_rst), .clk_en(clk_en), .warm_rst(warm_rst),
        .rd_idx(rd_idx), .rd_size(rd_size), .rd_data(rd_data),
        .wr_en(wr_en), .wr_idx(wr_idx), .wr_size(wr_size),
        .wr_data(wr_data), .dr_sel(dr_sel), .dr_wr(dr_wr),
        .dr_wdata(dr_wdata), .dr_rdata(dr_rdata), .pc_ld(pc_ld),
        .pc_next(pc_next), .pc(pc), .stk_access(stk_access),
        .exc_stk_access(exc_acc), .stack_ptr(sp),
        .interrupt_stack_pointer(istk), .illegal_address_trap(trap),
        .short_register_select(srs));
    carf_exec_model i_carf_exec_model (.clock(clock), .clk_en(clk_en),
        .warm_rst(warm_rst), .rd_idx(rd_idx), .rd_size(rd_size),
        .wr_en(wr_en), .wr_idx(wr_idx), .wr_size(wr_size),
        .wr_data(wr_data), .dr_sel(dr_sel), .dr_wr(dr_wr),
        .dr_wdata(dr_wdata), .pc_ld(pc_ld), .pc_next(pc_next),
        .stk_access(stk_access), .exc_stk_access(exc_acc));
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input logic [3:0] i, input carf_size_t s,
                         input logic [31:0] e);
        i_carf_exec_model.rd(i, s);
        chk("rd_data", e, rd_data);
    endtask
    task automatic end_of_test();
        $display("failures %0d cmp_count %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("pc", 32'h0000_1234, {8'h00, pc});
        chk("srs", 32'h0, {31'h0, srs});
        chk("trap", 32'h0, {31'h0, trap});
    endtask
    task automatic t_gpr();
        i_carf_exec_model.gpr_wr(4'h2, CARF_SZ_WORD, 32'hAAAA_1234, 1'b1);
        rdchk(4'h2, CARF_SZ_WORD, 32'h0000_1234);
        i_carf_exec_model.gpr_wr(4'h2, CARF_SZ_BYTE, 32'h0000_00CD, 1'b1);
        rdchk(4'h2, CARF_SZ_WORD, 32'h0000_12CD);
        rdchk(4'h2, CARF_SZ_BYTE, 32'h0000_00CD);
        i_carf_exec_model.gpr_wr(4'h2, CARF_SZ_WORD, 32'h0000_FFFF, 1'b0);
        rdchk(4'h2, CARF_SZ_WORD, 32'h0000_12CD);
        i_carf_exec_model.gpr_wr(4'h4, CARF_SZ_PAIR, 32'h7777_6666, 1'b1);
        rdchk(4'h5, CARF_SZ_WORD, 32'h0000_7777);
        i_carf_exec_model.gpr_wr(4'hC, CARF_SZ_PAIR, 32'h89AB_CDEF, 1'b1);
        i_carf_exec_model.gpr_wr(4'hC, CARF_SZ_WORD, 32'h5555_1111, 1'b1);
        rdchk(4'hC, CARF_SZ_PAIR, 32'h89AB_1111);
    endtask
    task automatic t_short();
        i_carf_exec_model.dr_write(CARF_DR_CFG, 32'h0000_0200);
        chk("srs", 32'h1, {31'h0, srs});
        i_carf_exec_model.gpr_wr(4'hC, CARF_SZ_PAIR, 32'h2468_1357, 1'b1);
        rdchk(4'hD, CARF_SZ_WORD, 32'h0000_2468);
        i_carf_exec_model.dr_write(CARF_DR_CFG, 32'h0000_0000);
        rdchk(4'hC, CARF_SZ_PAIR, 32'h89AB_1357);
    endtask
    task automatic t_pc();
        i_carf_exec_model.pulse(0, 24'hAB_CDEF);
        chk("pc", 32'h00AB_CDEE, {8'h00, pc});
        i_carf_exec_model.dr_write(CARF_DR_CFG, 32'h0000_0200);
        i_carf_exec_model.pulse(1, 24'h00_0000);
        rdchk(4'h0, CARF_SZ_PAIR, 32'h00AB_CDEE);
        chk("pc", 32'h0000_1234, {8'h00, pc});
        chk("srs", 32'h0, {31'h0, srs});
    endtask
    task automatic t_stack();
        i_carf_exec_model.dr_write(CARF_DR_ISTK, 32'hFFFF_FFFF);
        chk("istk", 32'h00FF_FFFE, istk);
        i_carf_exec_model.dr_write(CARF_DR_BASE, 32'h0012_3450);
        chk("base", 32'h0012_3450, dr_rdata);
        i_carf_exec_model.gpr_wr(4'hF, CARF_SZ_PAIR, 32'h0000_4000, 1'b1);
        i_carf_exec_model.dr_write(CARF_DR_USTK, 32'h0100_0000);
        i_carf_exec_model.dr_write(CARF_DR_PSW, 32'h0000_0008);
        chk("sp", 32'h0100_0000, sp);
        i_carf_exec_model.pulse(2, 24'h00_0000);
        chk("trap", 32'h1, {31'h0, trap});
        i_carf_exec_model.pulse(3, 24'h00_0000);
        chk("trap", 32'h0, {31'h0, trap});
        i_carf_exec_model.dr_write(CARF_DR_USTK, 32'h00FF_FFFF);
        i_carf_exec_model.pulse(2, 24'h00_0000);
        chk("trap", 32'h0, {31'h0, trap});
        i_carf_exec_model.dr_write(CARF_DR_PSW, 32'h0000_0000);
        chk("sp", 32'h0000_4000, sp);
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        t_reset();
        t_gpr();
        t_short();
        t_pc();
        t_stack();
        end_of_test();
    end
endmodule // carf_regfile_tb
